// file: rtl/ifmu_pkg.sv
// Shared constants for the interrupt flag and mask unit
package ifmu_pkg;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_MCU_CTRL = 6'h35;
  localparam logic [5:0] IDX_TFLAGS = 6'h38;
  localparam logic [5:0] IDX_TEN = 6'h39;
  localparam logic [5:0] IDX_PFLAGS = 6'h3a;
  localparam logic [5:0] IDX_PEN = 6'h3b;
  localparam logic [5:0] IDX_STATUS = 6'h3f;

  // Field positions
  localparam int BIT_PIN1 = 7;
  localparam int BIT_PIN0 = 6;
  localparam int BIT_T1_WRAP = 7;
  localparam int BIT_T1_MATCH = 6;
  localparam int BIT_T1_CAPT = 3;
  localparam int BIT_T0_WRAP = 1;
  localparam int BIT_GIE = 7;

  // Implemented bits per register, the rest read as zero
  localparam logic [7:0] PIN_MASK = 8'hc0;
  localparam logic [7:0] TIMER_MASK = 8'hca;
  localparam logic [7:0] MCU_MASK = 8'h0f;
  localparam logic [7:0] STATUS_MASK = 8'h80;
  localparam logic [7:0] REG_RESET = 8'h00;

  // Two-bit sense control codes
  localparam logic [1:0] SENSE_LOW = 2'h0;
  localparam logic [1:0] SENSE_RSVD = 2'h1;
  localparam logic [1:0] SENSE_FALL = 2'h2;
  localparam logic [1:0] SENSE_RISE = 2'h3;

  // Vector addresses, lower address wins
  typedef logic [3:0] ifmu_vec_t;
  localparam ifmu_vec_t VEC_NONE = 4'h0;
  localparam ifmu_vec_t VEC_PIN0 = 4'h1;
  localparam ifmu_vec_t VEC_PIN1 = 4'h2;
  localparam ifmu_vec_t VEC_T1_CAPT = 4'h3;
  localparam ifmu_vec_t VEC_T1_MATCH = 4'h4;
  localparam ifmu_vec_t VEC_T1_WRAP = 4'h5;
  localparam ifmu_vec_t VEC_T0_WRAP = 4'h6;
  localparam ifmu_vec_t VEC_OTHER0 = 4'h7;
  localparam int NUM_VEC = 11;

endpackage

// file: rtl/ifmu_pin_if.sv
// Signals between the controller and one pin sense unit
interface ifmu_pin_if;
  logic [1:0] sense;
  logic level_req;
  logic edge_hit;
  modport unit (input sense, output level_req, output edge_hit);
  modport ctrl (output sense, input level_req, input edge_hit);
endinterface

// file: rtl/ifmu_pin_sense.sv
// Sampling and edge or level detection for one external pin
module ifmu_pin_sense (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic pin,
  ifmu_pin_if.unit port_if
);

  logic sample_reg;
  logic prev_reg;
  wire rise = sample_reg & ~prev_reg;
  wire fall = ~sample_reg & prev_reg;

  // Idle-high reset so release never fakes a falling edge
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sample_reg <= 1'b1;
      prev_reg <= 1'b1;
    end else begin
      sample_reg <= pin;
      prev_reg <= sample_reg;
    end
  end

  // Level request lives only while the pin is low
  assign port_if.level_req = (port_if.sense == ifmu_pkg::SENSE_LOW)
                             & ~sample_reg;
  // Reserved code selects nothing
  assign port_if.edge_hit =
    ((port_if.sense == ifmu_pkg::SENSE_FALL) & fall) |
    ((port_if.sense == ifmu_pkg::SENSE_RISE) & rise);

endmodule // ifmu_pin_sense

// file: rtl/ifmu_ctrl.sv
// Interrupt flag, mask and priority controller with AHB-Lite registers
// What this block does
// RQ1 - Taking an interrupt clears global enable
// RQ2 - Return instruction or software sets global enable
// RQ3 - Flags set only on events, not conditions
// RQ4 - Vectoring clears the served source's flag
// RQ5 - Flags set even while individually disabled
// RQ6 - Pending flags served by priority once enabled
// RQ7 - Level pin request has no stored flag
// RQ8 - Status register never saved or restored
// RQ9 - Pin 1 enable bit 7, vector 002
// RQ10 - Pin 0 enable bit 6, vector 001
// RQ11 - Pin raises request even as output
// RQ12 - Two-bit field selects rise, fall, level
// RQ13 - Pin edge sets flag bit 7 or 6
// RQ14 - Writing one clears a flag, zero keeps
// RQ15 - Level mode holds the pin flag zero
// RQ16 - Reserved register bits read as zero
// RQ17 - Timer1 wrap enable bit 7, vector 005
// RQ18 - Timer1 match enable bit 6, vector 004
// RQ19 - Timer1 capture enable bit 3, vector 003
// RQ20 - Timer0 wrap enable bit 1, vector 006
// RQ21 - Timer flags at bits 7, 6, 3, 1
// RQ22 - PWM direction turn at zero sets wrap
// RQ23 - Lower vector address wins priority
// RQ24 - Sense codes: low, reserved, fall, rise
// RQ25 - Pins sampled before edge detection
// RQ26 - One main instruction runs after return
// RQ27 - Hardware set beats software clear
//
// The AHB-Lite interface to the registers was left to the implementer.
module ifmu_ctrl #(
  parameter int OTHER_N = 4
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic ext_pin0_request,
  input wire logic ext_pin1_request,
  input wire logic t1_wrap_event,
  input wire logic t1_pwm_mode,
  input wire logic t1_pwm_turn_event,
  input wire logic t1_match_event,
  input wire logic t1_capture_event,
  input wire logic t0_wrap_event,
  input wire logic [OTHER_N-1:0] other_req,
  input wire logic irq_take,
  input wire logic return_exec,
  input wire logic instr_done,
  output logic irq_req,
  output logic [3:0] irq_vector,
  output logic gie
);

  // Lowest set index wins
  function automatic ifmu_pkg::ifmu_vec_t ifmu_pick(
    input logic [ifmu_pkg::NUM_VEC-1:0] p);
    ifmu_pick = ifmu_pkg::VEC_NONE;
    for (int i = ifmu_pkg::NUM_VEC - 1; i >= 1; i--) begin
      if (p[i]) begin
        ifmu_pick = 4'(i);
      end
    end
  endfunction

  logic [7:0] tflags_reg;
  logic [7:0] tflags_next;
  logic [7:0] ten_reg;
  logic [7:0] pflags_reg;
  logic [7:0] pflags_next;
  logic [7:0] pen_reg;
  logic [7:0] mcu_ctrl_reg;
  logic gie_reg;
  logic gie_next;
  logic after_return_reg;
  logic wr_en_reg;
  logic [5:0] wr_idx_reg;
  logic hreadyout_reg;
  logic hresp_reg;
  logic [31:0] hrdata_reg;
  logic irq_req_reg;
  logic irq_req_next;
  ifmu_pkg::ifmu_vec_t irq_vector_reg;
  logic [7:0] rd_val;

  // AHB address phase decode
  wire addr_ok = hsel & htrans[1] & hready;
  wire mapped = (haddr[31:8] == 24'h0) & (haddr[1:0] == 2'h0);
  wire [5:0] idx_a = haddr[7:2];

  // Data phase write strobes, low byte only
  wire [7:0] wdat = hwdata[7:0];
  wire wr_tflags = wr_en_reg & (wr_idx_reg == ifmu_pkg::IDX_TFLAGS);
  wire wr_ten = wr_en_reg & (wr_idx_reg == ifmu_pkg::IDX_TEN);
  wire wr_pflags = wr_en_reg & (wr_idx_reg == ifmu_pkg::IDX_PFLAGS);
  wire wr_pen = wr_en_reg & (wr_idx_reg == ifmu_pkg::IDX_PEN);
  wire wr_mcu = wr_en_reg & (wr_idx_reg == ifmu_pkg::IDX_MCU_CTRL);
  wire wr_status = wr_en_reg & (wr_idx_reg == ifmu_pkg::IDX_STATUS);

  // Pin sense units; pin level is read whatever the pin direction
  ifmu_pin_if pin_if [2] ();
  logic [1:0] pin_in;
  logic [1:0] edge_hit;
  logic [1:0] level_req;
  logic [1:0] level_mode;
  assign pin_in = {ext_pin1_request, ext_pin0_request}; // RQ11
  genvar g;
  for (g = 0; g < 2; g++) begin : g_pin
    assign pin_if[g].sense = mcu_ctrl_reg[2*g+1 -: 2]; // RQ12 RQ24
    ifmu_pin_sense u_sense (
      .clk_sys(clk_sys),
      .reset(reset),
      .pin(pin_in[g]),
      .port_if(pin_if[g])
    ); // RQ25
    assign edge_hit[g] = pin_if[g].edge_hit;
    assign level_req[g] = pin_if[g].level_req; // RQ7
    assign level_mode[g] = (pin_if[g].sense == ifmu_pkg::SENSE_LOW);
  end

  // Hardware clear of the flag whose vector is taken
  wire take_pin0 = irq_take & (irq_vector_reg == ifmu_pkg::VEC_PIN0);
  wire take_pin1 = irq_take & (irq_vector_reg == ifmu_pkg::VEC_PIN1);
  wire take_capt = irq_take & (irq_vector_reg == ifmu_pkg::VEC_T1_CAPT);
  wire take_match = irq_take & (irq_vector_reg == ifmu_pkg::VEC_T1_MATCH);
  wire take_t1w = irq_take & (irq_vector_reg == ifmu_pkg::VEC_T1_WRAP);
  wire take_t0w = irq_take & (irq_vector_reg == ifmu_pkg::VEC_T0_WRAP);

  // Timer flag set, clear and next value; set wins over clear
  logic [7:0] t_set;
  logic [7:0] t_clr;
  always_comb begin
    t_set = 8'h00;
    t_set[ifmu_pkg::BIT_T1_WRAP] = t1_pwm_mode ? t1_pwm_turn_event
                                               : t1_wrap_event; // RQ22
    t_set[ifmu_pkg::BIT_T1_MATCH] = t1_match_event; // RQ3
    t_set[ifmu_pkg::BIT_T1_CAPT] = t1_capture_event;
    t_set[ifmu_pkg::BIT_T0_WRAP] = t0_wrap_event; // RQ21
    t_clr = wr_tflags ? wdat : 8'h00; // RQ14
    t_clr[ifmu_pkg::BIT_T1_WRAP] |= take_t1w; // RQ4
    t_clr[ifmu_pkg::BIT_T1_MATCH] |= take_match;
    t_clr[ifmu_pkg::BIT_T1_CAPT] |= take_capt;
    t_clr[ifmu_pkg::BIT_T0_WRAP] |= take_t0w;
    tflags_next = ((tflags_reg & ~t_clr) | t_set)
                  & ifmu_pkg::TIMER_MASK; // RQ27 RQ5 RQ16
  end

  // Pin flag update; level mode forces the flag to zero
  logic [7:0] p_set;
  logic [7:0] p_clr;
  logic [7:0] p_hold0;
  always_comb begin
    p_set = 8'h00;
    p_set[ifmu_pkg::BIT_PIN1] = edge_hit[1]; // RQ13
    p_set[ifmu_pkg::BIT_PIN0] = edge_hit[0];
    p_clr = wr_pflags ? wdat : 8'h00; // RQ14
    p_clr[ifmu_pkg::BIT_PIN1] |= take_pin1; // RQ4
    p_clr[ifmu_pkg::BIT_PIN0] |= take_pin0;
    p_hold0 = 8'h00;
    p_hold0[ifmu_pkg::BIT_PIN1] = level_mode[1]; // RQ15
    p_hold0[ifmu_pkg::BIT_PIN0] = level_mode[0];
    pflags_next = ((pflags_reg & ~p_clr) | p_set)
                  & ifmu_pkg::PIN_MASK & ~p_hold0; // RQ27 RQ16
  end

  // Pending requests indexed by vector address
  logic [ifmu_pkg::NUM_VEC-1:0] pend;
  always_comb begin
    pend = '0;
    pend[ifmu_pkg::VEC_PIN0] = (pflags_reg[ifmu_pkg::BIT_PIN0]
      | level_req[0]) & pen_reg[ifmu_pkg::BIT_PIN0]; // RQ10 RQ7
    pend[ifmu_pkg::VEC_PIN1] = (pflags_reg[ifmu_pkg::BIT_PIN1]
      | level_req[1]) & pen_reg[ifmu_pkg::BIT_PIN1]; // RQ9
    pend[ifmu_pkg::VEC_T1_CAPT] = tflags_reg[ifmu_pkg::BIT_T1_CAPT]
      & ten_reg[ifmu_pkg::BIT_T1_CAPT]; // RQ19
    pend[ifmu_pkg::VEC_T1_MATCH] = tflags_reg[ifmu_pkg::BIT_T1_MATCH]
      & ten_reg[ifmu_pkg::BIT_T1_MATCH]; // RQ18
    pend[ifmu_pkg::VEC_T1_WRAP] = tflags_reg[ifmu_pkg::BIT_T1_WRAP]
      & ten_reg[ifmu_pkg::BIT_T1_WRAP]; // RQ17
    pend[ifmu_pkg::VEC_T0_WRAP] = tflags_reg[ifmu_pkg::BIT_T0_WRAP]
      & ten_reg[ifmu_pkg::BIT_T0_WRAP]; // RQ20
    pend[ifmu_pkg::VEC_OTHER0 +: OTHER_N] = other_req;
  end

  // Request only with global enable, outside the post-return slot
  wire ifmu_pkg::ifmu_vec_t best = ifmu_pick(pend); // RQ23 RQ6
  assign irq_req_next = (best != ifmu_pkg::VEC_NONE) & gie_reg
                        & ~after_return_reg & ~irq_take; // RQ26

  // Taking wins over return, which wins over a software write
  always_comb begin
    gie_next = gie_reg;
    if (irq_take) begin
      gie_next = 1'b0; // RQ1
    end else if (return_exec) begin
      gie_next = 1'b1; // RQ2
    end else if (wr_status) begin
      gie_next = wdat[ifmu_pkg::BIT_GIE];
    end
  end

  // Register read mux; unmapped indices read zero
  always_comb begin
    unique case (idx_a)
      ifmu_pkg::IDX_TFLAGS: rd_val = tflags_reg;
      ifmu_pkg::IDX_TEN: rd_val = ten_reg;
      ifmu_pkg::IDX_PFLAGS: rd_val = pflags_reg;
      ifmu_pkg::IDX_PEN: rd_val = pen_reg;
      ifmu_pkg::IDX_MCU_CTRL: rd_val = mcu_ctrl_reg;
      ifmu_pkg::IDX_STATUS: rd_val = {gie_reg, 7'h00};
      default: rd_val = 8'h00;
    endcase
  end

  // Bus side: zero wait states, always OKAY
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wr_en_reg <= 1'b0;
      wr_idx_reg <= 6'h00;
      hreadyout_reg <= 1'b1;
      hresp_reg <= 1'b0;
      hrdata_reg <= 32'h0;
    end else begin
      wr_en_reg <= addr_ok & hwrite & mapped;
      wr_idx_reg <= idx_a;
      hrdata_reg <= (addr_ok & ~hwrite & mapped) ? {24'h0, rd_val}
                                                 : 32'h0; // RQ16
    end
  end

  // Enable and control registers, reserved bits kept at zero
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ten_reg <= ifmu_pkg::REG_RESET;
      pen_reg <= ifmu_pkg::REG_RESET;
      mcu_ctrl_reg <= ifmu_pkg::REG_RESET;
    end else begin
      if (wr_ten) begin
        ten_reg <= wdat & ifmu_pkg::TIMER_MASK; // RQ16
      end
      if (wr_pen) begin
        pen_reg <= wdat & ifmu_pkg::PIN_MASK;
      end
      if (wr_mcu) begin
        mcu_ctrl_reg <= wdat & ifmu_pkg::MCU_MASK;
      end
    end
  end

  // Flags, global enable and the core handshake
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      tflags_reg <= ifmu_pkg::REG_RESET;
      pflags_reg <= ifmu_pkg::REG_RESET;
      gie_reg <= 1'b0;
      after_return_reg <= 1'b0;
      irq_req_reg <= 1'b0;
      irq_vector_reg <= ifmu_pkg::VEC_NONE;
    end else begin
      tflags_reg <= tflags_next;
      pflags_reg <= pflags_next;
      gie_reg <= gie_next;
      after_return_reg <= return_exec | (after_return_reg & ~instr_done);
      irq_req_reg <= irq_req_next;
      irq_vector_reg <= irq_req_next ? best : ifmu_pkg::VEC_NONE;
    end
  end

  // No status save on entry or exit: the routine must do it (RQ8)
  assign hreadyout = hreadyout_reg;
  assign hresp = hresp_reg;
  assign hrdata = hrdata_reg;
  assign irq_req = irq_req_reg;
  assign irq_vector = irq_vector_reg;
  assign gie = gie_reg;

  // Checks on the block's own behaviour
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  property p_take_clears_gie;
    irq_take |=> !gie_reg;
  endproperty
  a_take_clears_gie: assert property (p_take_clears_gie) // RQ1
    else $error("global enable not cleared on take");

  property p_return_sets_gie;
    return_exec && !irq_take |=> gie_reg;
  endproperty
  a_return_sets_gie: assert property (p_return_sets_gie) // RQ2
    else $error("global enable not set on return");

  sequence s_take_t1w;
    take_t1w && !t_set[ifmu_pkg::BIT_T1_WRAP];
  endsequence
  property p_take_clears_flag;
    s_take_t1w |=> !tflags_reg[ifmu_pkg::BIT_T1_WRAP];
  endproperty
  a_take_clears_flag: assert property (p_take_clears_flag) // RQ4
    else $error("served flag not cleared");

  property p_event_sets_flag;
    t1_match_event |=> tflags_reg[ifmu_pkg::BIT_T1_MATCH];
  endproperty
  a_event_sets_flag: assert property (p_event_sets_flag) // RQ5 RQ27
    else $error("match event did not set its flag");

  property p_sw_clear;
    wr_pflags && wdat[ifmu_pkg::BIT_PIN0] && !edge_hit[0]
      |=> !pflags_reg[ifmu_pkg::BIT_PIN0];
  endproperty
  a_sw_clear: assert property (p_sw_clear) // RQ14
    else $error("write one did not clear pin flag");

  property p_level_no_flag;
    level_mode[1] |=> !pflags_reg[ifmu_pkg::BIT_PIN1] || !level_mode[1];
  endproperty
  a_level_no_flag: assert property (p_level_no_flag) // RQ15
    else $error("pin flag set in level mode");

  property p_reserved_zero;
    hrdata_reg[31:8] == 24'h0 && (hrdata_reg[7:0] & ~(
      ifmu_pkg::PIN_MASK | ifmu_pkg::TIMER_MASK | ifmu_pkg::MCU_MASK))
      == 8'h00
      && (ten_reg & ~ifmu_pkg::TIMER_MASK) == 8'h00
      && (tflags_reg & ~ifmu_pkg::TIMER_MASK) == 8'h00
      && (pen_reg & ~ifmu_pkg::PIN_MASK) == 8'h00
      && (pflags_reg & ~ifmu_pkg::PIN_MASK) == 8'h00
      && (mcu_ctrl_reg & ~ifmu_pkg::MCU_MASK) == 8'h00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) // RQ16
    else $error("reserved bits read nonzero");

  property p_hold_after_return;
    after_return_reg |=> !irq_req_reg;
  endproperty
  a_hold_after_return: assert property (p_hold_after_return) // RQ26
    else $error("request raised before one instruction ran");

  sequence s_pin0_ready;
    pend[ifmu_pkg::VEC_PIN0] && gie_reg && !after_return_reg && !irq_take;
  endsequence
  property p_pin0_first;
    s_pin0_ready |=> irq_req_reg && irq_vector_reg == ifmu_pkg::VEC_PIN0;
  endproperty
  a_pin0_first: assert property (p_pin0_first) // RQ23 RQ10
    else $error("pin 0 request not given top priority");

  property p_no_req_without_gie;
    !gie_reg |=> !irq_req_reg;
  endproperty
  a_no_req_without_gie: assert property (p_no_req_without_gie) // RQ6
    else $error("request raised while globally disabled");

endmodule // ifmu_ctrl

// file: verif/ifmu_core_model.sv
// Behavioural core that takes, serves and returns from requests
module ifmu_core_model (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic irq_req,
  input wire logic [3:0] irq_vector,
  input wire logic [3:0] lag,
  output logic irq_take,
  output logic return_exec,
  output logic instr_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] seen_q[$];
  logic [1:0] st;
  logic [3:0] cnt;
  int bad = 0;
  // States: idle, inside routine, waiting for one main instruction
  always @(posedge clk_sys) begin
    irq_take <= 1'b0;
    return_exec <= 1'b0;
    instr_done <= 1'b0;
    if (reset) begin
      st <= 2'h0;
      cnt <= 4'h0;
    end else if (st == 2'h0) begin
      // Lag mimics a long instruction finishing before the take
      cnt <= (irq_req === 1'b1) ? cnt + 4'h1 : 4'h0;
      if (irq_req === 1'b1 && cnt == lag) begin
        irq_take <= 1'b1;
        seen_q.push_back(irq_vector);
        st <= 2'h1;
        cnt <= 4'h0;
      end
    end else begin
      // Request stays down in the routine and until one instruction
      if ((cnt != 4'h0 || st == 2'h2) && irq_req !== 1'b0) bad++;
      cnt <= cnt + 4'h1;
      if (cnt == (st == 2'h1 ? 4'h5 : 4'h3)) begin
        return_exec <= (st == 2'h1);
        instr_done <= (st == 2'h2);
        st <= (st == 2'h1) ? 2'h2 : 2'h0;
        cnt <= 4'h0;
      end
    end
  end
endmodule // ifmu_core_model

// file: verif/testbench.sv
// Self-checking bench for the interrupt flag and mask unit
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, hreadyout, hresp, irq_req, gie;
  logic irq_take, return_exec, instr_done;
  logic [3:0] oreq = 4'h0;
  logic reset = 1'b1, hsel = 1'b0, hwrite = 1'b0, pwm = 1'b0;
  logic pin0 = 1'b1, pin1 = 1'b1;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, x;
  logic [3:0] irq_vector, lag = 4'h0;
  logic [4:0] ev = 5'h0;
  // Index table: timer en, pin en, mcu, status, unmapped, timer fl, pin fl
  logic [5:0] ra [7];
  logic [7:0] wm [5];
  logic [7:0] tbit [4];
  int err_total = 0, cmp_count = 0;
  // Word size fixed; oreq stands in for serial and comparator lines
  ifmu_ctrl uut (
    .clk_sys(clk_sys), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .ext_pin0_request(pin0), .ext_pin1_request(pin1),
    .t1_wrap_event(ev[0]), .t1_pwm_mode(pwm), .t1_pwm_turn_event(ev[4]),
    .t1_match_event(ev[1]), .t1_capture_event(ev[2]),
    .t0_wrap_event(ev[3]), .other_req(oreq), .irq_take(irq_take),
    .return_exec(return_exec), .instr_done(instr_done), .irq_req(irq_req),
    .irq_vector(irq_vector), .gie(gie)
  );
  ifmu_core_model core (
    .clk_sys(clk_sys), .reset(reset), .irq_req(irq_req),
    .irq_vector(irq_vector), .lag(lag), .irq_take(irq_take),
    .return_exec(return_exec), .instr_done(instr_done)
  );
  task automatic chk(input string nm, input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic hang();
    err_total++;
    end_sim();
  endtask
  // Ready is a flop output, so its pre-edge value is read at the edge
  task automatic rdy_wait();
    int n;
    for (n = 0; n < 100; n++) begin
      @(posedge clk_sys);
      if (hreadyout === 1'b1) break;
    end
    if (n >= 100) hang();
  endtask
  // One single-word transfer; each phase held until ready is seen
  task automatic bus(input logic wr_en, input logic [5:0] idx,
      input logic [7:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr_en;
    haddr <= {24'h0, idx, 2'h0};
    rdy_wait();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    rdy_wait();
    x = hrdata;
    chk("hresp", {31'h0, hresp}, 32'h0);
  endtask
  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
  endtask
  task automatic rc(input string nm, input logic [5:0] idx,
      input logic [7:0] e);
    bus(1'b0, idx, 8'h00);
    chk(nm, x, {24'h0, e});
  endtask
  // One-cycle event pulse with new pin levels, then time to settle
  task automatic stim(input logic [4:0] m, input logic [1:0] p);
    ev <= m;
    {pin1, pin0} <= p;
    @(posedge clk_sys);
    ev <= 5'h0;
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic wait_take(input int k);
    int n;
    for (n = 0; n < 500; n++) begin
      if (core.seen_q.size() >= k) break;
      @(posedge clk_sys);
    end
    if (n >= 500) hang();
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Hard stop so that a hang still reaches the verdict
  initial begin
    repeat (20000) @(posedge clk_sys);
    hang();
  end
  initial begin
    logic [31:0] s;
    logic [7:0] e;
    ra = '{ifmu_pkg::IDX_TEN, ifmu_pkg::IDX_PEN, ifmu_pkg::IDX_MCU_CTRL,
      ifmu_pkg::IDX_STATUS, 6'h10, ifmu_pkg::IDX_TFLAGS,
      ifmu_pkg::IDX_PFLAGS};
    wm = '{ifmu_pkg::TIMER_MASK, ifmu_pkg::PIN_MASK, ifmu_pkg::MCU_MASK,
      ifmu_pkg::STATUS_MASK, 8'h00};
    tbit = '{8'h80, 8'h40, 8'h08, 8'h02};
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    for (int i = 0; i < 7; i++) rc("reset", ra[i], 8'h00);
    $display("test reset done");
    // Only implemented bits stick; unmapped writes vanish
    for (int i = 0; i < 5; i++) begin
      wr(ra[i], 8'hff);
      rc("mask", ra[i], wm[i]);
    end
    chk("gie", {31'h0, gie}, 32'h1);
    for (int i = 0; i < 4; i++) wr(ra[i], 8'h00);
    $display("test mask done");
    // Timer events latch with enables off and clear only by a one
    e = 8'h00;
    for (int i = 0; i < 4; i++) begin
      stim(5'h01 << i, 2'b11);
      e = e | tbit[i];
      rc("tflags", ra[5], e);
    end
    wr(ra[5], 8'h40);
    rc("w1c", ra[5], 8'h8a);
    wr(ra[5], 8'h00);
    repeat (8) @(posedge clk_sys);
    rc("w0", ra[5], 8'h8a);
    wr(ra[5], 8'hff);
    pwm <= 1'b1;
    stim(5'h01, 2'b11);
    rc("pwm wrap", ra[5], 8'h00);
    stim(5'h10, 2'b11);
    rc("pwm turn", ra[5], 8'h80);
    pwm <= 1'b0;
    wr(ra[5], 8'h80);
    $display("test timer flags done");
    // Every sense code against a low pulse on both pins
    for (int c = 0; c < 4; c++) begin
      wr(ra[2], {4'h0, c[1:0], c[1:0]});
      wr(ra[6], 8'hff);
      stim(5'h00, 2'b00);
      stim(5'h00, 2'b11);
      rc("sense", ra[6], c[1] ? 8'hc0 : 8'h00);
    end
    $display("test sense done");
    // Pending sources wait for global enable, then lowest vector first
    wr(ra[2], 8'h0a);
    wr(ra[6], 8'hff);
    wr(ra[0], 8'hca);
    wr(ra[1], 8'hc0);
    lag <= 4'h2;
    stim(5'h0f, 2'b00);
    rc("pending", ra[5], 8'hca);
    rc("pending", ra[6], 8'hc0);
    chk("irq_req", {31'h0, irq_req}, 32'h0);
    core.seen_q.delete();
    wr(ra[3], 8'h80);
    wait_take(6);
    repeat (20) @(posedge clk_sys);
    for (int i = 0; i < 6; i++) begin
      s = 32'(core.seen_q[i]);
      chk("vec", s, i + 1);
    end
    chk("takes", 32'(core.seen_q.size()), 32'h6);
    rc("served", ra[5], 8'h00);
    rc("served", ra[6], 8'h00);
    chk("gie", {31'h0, gie}, 32'h1);
    stim(5'h00, 2'b11);
    $display("test priority done");
    // Low level asks again after each return and leaves no flag
    lag <= 4'h0;
    wr(ra[2], 8'h00);
    wr(ra[1], 8'h40);
    core.seen_q.delete();
    stim(5'h00, 2'b10);
    // Raised five cycles after the pin so the pin sample has landed
    oreq <= 4'h8;
    wait_take(2);
    stim(5'h00, 2'b11);
    repeat (30) @(posedge clk_sys);
    s = 32'(core.seen_q[core.seen_q.size() - 1]);
    chk("other last", s, 32'ha);
    oreq <= 4'h0;
    repeat (30) @(posedge clk_sys);
    s = 32'(core.seen_q.size());
    repeat (30) @(posedge clk_sys);
    chk("level stop", 32'(core.seen_q.size()), s);
    chk("level vec", 32'(core.seen_q[0]), 32'h1);
    chk("both vec", 32'(core.seen_q[1]), 32'h1);
    rc("level flag", ra[6], 8'h00);
    chk("early req", 32'(core.bad), 32'h0);
    $display("test level done");
    end_sim();
  end
endmodule // testbench
